// >>> dco_pkg.sv
// Purpose: shared constants for the oscillator loop control block
// Assumes: 20 MHz system clock, APB register access
// Notes:   offsets are byte addresses of 32-bit words
package dco_pkg;
  // ==========================================================
  // clocking and reference
  localparam int unsigned CLK_HZ        = 20000000;
  localparam int unsigned BASE_HZ_X10   = 3072000;   // 307.2 kHz
  localparam int unsigned REF_CYCLES    = CLK_HZ * 10 / BASE_HZ_X10;
  localparam int unsigned CORR_BASE_PER = 4;         // base periods
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_MULT   = 8'h04;
  localparam logic [7:0] OFF_TRIM   = 8'h08;
  localparam logic [7:0] OFF_DIV    = 8'h0c;
  localparam logic [7:0] OFF_STAGE  = 8'h10;
  localparam logic [7:0] OFF_REF    = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  // ==========================================================
  // reset values and field limits
  localparam logic [6:0]  MULT_RST  = 7'h54;
  localparam logic [7:0]  TRIM_RST  = 8'h80;
  localparam logic [3:0]  DIV_RST   = 4'h0;
  localparam logic [7:0]  STAGE_RST = 8'h60;
  localparam logic [9:0]  REF_RST   = 10'(REF_CYCLES);
  localparam logic [3:0]  DIV_MAX   = 4'h9;
  localparam logic [11:0] STEP_COARSE = 12'h020;
  localparam logic [11:0] STEP_MEDIUM = 12'h008;
  localparam logic [11:0] STEP_FINE   = 12'h001;
  localparam int unsigned ERR_COARSE_PCT = 15;
  localparam int unsigned ERR_FINE_PCT   = 5;
  localparam logic [4:0]  RING_MIN  = 5'd17;
  localparam logic [4:0]  RING_MAX  = 5'd31;
  // ==========================================================
  // loop filter modes, gray coded along the settling path
  typedef enum logic [1:0] {
    MODE_IDLE   = 2'b00,
    MODE_COARSE = 2'b01,
    MODE_MEDIUM = 2'b11,
    MODE_FINE   = 2'b10
  } mode_t;
endpackage : dco_pkg

// >>> fine_adjust_dither.sv
// Purpose: per-cycle ring length from the stage control word
// Assumes: one oscillator cycle per clock edge
// Notes:   long setting is taken for the first cycles of each frame
`timescale 1ns/1ps
module fine_adjust_dither
  import dco_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] stage_i,
  output logic      [4:0] ring_stages_o,
  output logic            ring_div2_o,
  output logic            ring_long_o
);
  logic [4:0] phase_reg;
  logic [4:0] phase_next;
  logic [4:0] stages_reg;
  logic [4:0] stages_next;
  logic       div2_reg;
  logic       div2_next;
  logic       long_reg;
  logic       long_next;

  // ==========================================================
  // frame of 32 cycles, long for stage_i[4:0] of them
  always_comb begin
    phase_next = phase_reg + 5'd1;
    long_next  = (phase_reg < stage_i[4:0]);
    div2_next  = 1'b0;
    stages_next = RING_MIN + {stage_i[7:5], 1'b0};
    if (stage_i[7:5] == 3'h7) begin
      // top row: 31 base, long is 17 halved (34 effective)
      stages_next = long_next ? RING_MIN : RING_MAX;
      div2_next   = long_next;
    end else if (long_next) begin
      stages_next = stages_next + 5'd2;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      phase_reg  <= 5'h00;
      stages_reg <= RING_MIN;
      div2_reg   <= 1'b0;
      long_reg   <= 1'b0;
    end else begin
      phase_reg  <= phase_next;
      stages_reg <= stages_next;
      div2_reg   <= div2_next;
      long_reg   <= long_next;
    end
  end

  assign ring_stages_o = stages_reg;
  assign ring_div2_o   = div2_reg;
  assign ring_long_o   = long_reg;

  // ==========================================================
  // checks
  zero_fine_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (stage_i == 8'h60) |=> (ring_stages_o == 5'd23 && !ring_div2_o))
    else $error("zero fine bits did not hold 23 stages");
  div2_pair_a: assert property (@(posedge clock_i) disable iff (rst_i)
    ring_div2_o |-> (ring_stages_o == 5'd17))
    else $error("divide by two without 17 stage ring");
  long_phase_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (phase_reg < stage_i[4:0]) |=> ring_long_o)
    else $error("long setting missed inside frame");
endmodule : fine_adjust_dither

// >>> base_period_meter.sv
// Purpose: derive base ticks and time four of them in clock cycles
// Assumes: internal_clk_i is asynchronous and slower than clock_i/2
// Notes:   a zero multiply factor is treated as one
`timescale 1ns/1ps
module base_period_meter
  import dco_pkg::*;
#(
  parameter int CNT_W  = 14,
  parameter int MULT_W = 7
) (
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  input  wire logic              clear_i,
  input  wire logic              internal_clk_i,
  input  wire logic [MULT_W-1:0] mult_i,
  output logic                   meas_valid_o,
  output logic      [CNT_W-1:0]  meas_count_o
);
  logic [2:0]        sync_reg;
  logic [MULT_W-1:0] edge_cnt_reg, edge_cnt_next;
  logic [1:0]        base_cnt_reg, base_cnt_next;
  logic [CNT_W-1:0]  cyc_reg, cyc_next;
  logic [CNT_W-1:0]  count_reg, count_next;
  logic              valid_reg, valid_next;
  logic              rise;
  logic              tick;

  // ==========================================================
  // internal clock edges, base tick every mult_i edges
  always_comb begin
    rise = sync_reg[1] && !sync_reg[2];   // first stage never read
    tick = rise && (edge_cnt_reg + 1'b1 >= mult_i);
    edge_cnt_next = rise ? edge_cnt_reg + 1'b1 : edge_cnt_reg;
    base_cnt_next = tick ? base_cnt_reg + 2'd1 : base_cnt_reg;
    cyc_next   = (&cyc_reg) ? cyc_reg : cyc_reg + 1'b1;
    count_next = count_reg;
    valid_next = 1'b0;
    if (tick) begin
      edge_cnt_next = '0;
    end
    // one correction per four base periods
    if (tick && base_cnt_reg == 2'(CORR_BASE_PER - 1)) begin
      valid_next = 1'b1;
      // the incremented value, so the closing cycle is counted too
      count_next = cyc_next;
      cyc_next   = '0;
    end
    if (clear_i) begin
      edge_cnt_next = '0;
      base_cnt_next = 2'd0;
      cyc_next      = '0;
      valid_next    = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sync_reg     <= 3'h0;
      edge_cnt_reg <= '0;
      base_cnt_reg <= 2'd0;
      cyc_reg      <= '0;
      count_reg    <= '0;
      valid_reg    <= 1'b0;
    end else begin
      sync_reg     <= {sync_reg[1:0], internal_clk_i};
      edge_cnt_reg <= edge_cnt_next;
      base_cnt_reg <= base_cnt_next;
      cyc_reg      <= cyc_next;
      count_reg    <= count_next;
      valid_reg    <= valid_next;
    end
  end

  assign meas_valid_o = valid_reg;
  assign meas_count_o = count_reg;

  four_base_a: assert property (@(posedge clock_i) disable iff (rst_i)
    meas_valid_o |-> $past(base_cnt_reg) == 2'd3 && base_cnt_reg == 2'd0)
    else $error("measurement not closed on fourth base tick");
endmodule : base_period_meter

// >>> dco_loop_settling_control.sv
// Purpose: loop filter control of the digitally controlled oscillator
// Assumes: APB slave, zero wait states, internal_clk_i async pin
// Notes:   loop value is {divider_ctrl, stage_ctrl}, twelve bits
`timescale 1ns/1ps
// Notes on behaviour
// - stage_ctrl[4:0] of every 32 cycles use two more stage delays, three more with upper bits 111
// - upper bits 011 give 23 delays; zero fine bits stay at 23
// - upper bits 111 dither 31 against 17 halved, 34 effective
// - lowest stage bit is the smallest loop correction step
// - internal clock is multiply factor times base clock
// - clock monitor cannot be enabled until stable flag is set
// - multiply factor writes are never blocked by hardware
// - settling restarts on reset, factor or trim change, re-enable
// - each correction spans four base clock periods
// - above 15 percent error, coarse steps; eight double the period
// - between 15 and 5 percent, medium steps of eight fine units
// - stable flag sets once error falls below 5 percent
// - below 5 percent, single fine steps until minimum error
// - divider field saturates at 9; larger codes act as 9
// - while enabled, divider changes only by carry or borrow from stage field
// - upper stage bits pick 17 to 31 delays in steps of two
// - while disabled, software writes divider and stage values
module dco_loop_settling_control
  import dco_pkg::*;
#(
  parameter int CNT_W = 14
) (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        internal_clk_i,
  input  wire logic        clk_monitor_flag_i,
  output logic      [7:0]  stage_ctrl_o,
  output logic      [3:0]  divider_ctrl_o,
  output logic      [4:0]  ring_stages_o,
  output logic             ring_div2_o,
  output logic             clk_stable_o,
  output logic             monitor_enable_o,
  output logic      [6:0]  mult_factor_o,
  output logic      [7:0]  trim_o
);
  // ==========================================================
  // state
  logic        gen_en_reg, gen_en_next;
  logic        mon_en_reg, mon_en_next;
  logic        stable_reg, stable_next;
  logic [6:0]  mult_reg, mult_next;
  logic [7:0]  trim_reg, trim_next;
  logic [3:0]  div_reg, div_next;
  logic [7:0]  stage_reg, stage_next;
  logic [9:0]  ref_reg, ref_next;
  mode_t       mode_reg, mode_next;
  logic [3:0]  div_out_reg, div_out_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;

  // ==========================================================
  // combinational helpers
  logic             setup;
  logic             wr;
  logic             mapped;
  logic             restart;
  logic             corr_fire;
  logic             meas_valid;
  logic [CNT_W-1:0] meas_count;
  logic [CNT_W-1:0] ref4;
  logic [CNT_W-1:0] err;
  logic [21:0]      err_pct;
  logic [21:0]      ref_pct;
  logic             step_up;
  mode_t            band;
  logic [11:0]      loop_val;
  logic [11:0]      step;
  logic [12:0]      sum;
  logic [11:0]      corr_val;

  // ==========================================================
  // submodules
  base_period_meter #(
    .CNT_W  (CNT_W),
    .MULT_W (7)
  ) u_meter (
    .clock_i        (clock_i),
    .rst_i          (rst_i),
    .clear_i        (restart || !gen_en_reg),
    .internal_clk_i (internal_clk_i),
    .mult_i         (mult_reg),
    .meas_valid_o   (meas_valid),
    .meas_count_o   (meas_count)
  );

  fine_adjust_dither u_dither (
    .clock_i       (clock_i),
    .rst_i         (rst_i),
    .stage_i       (stage_reg),
    .ring_stages_o (ring_stages_o),
    .ring_div2_o   (ring_div2_o),
    .ring_long_o   ()
  );

  // ==========================================================
  // error band and loop arithmetic
  always_comb begin
    ref4    = CNT_W'({ref_reg, 2'b00});          // four base periods
    step_up = (meas_count < ref4);  // base too short: lengthen
    err     = step_up ? ref4 - meas_count : meas_count - ref4;
    err_pct = 22'(err) * 22'd100;
    ref_pct = 22'(ref4) * 22'(ERR_FINE_PCT);
    // percent compare without a divider
    if (err_pct > 22'(ref4) * 22'(ERR_COARSE_PCT)) begin
      band = MODE_COARSE;
      step = STEP_COARSE;
    end else if (err_pct > ref_pct) begin
      band = MODE_MEDIUM;
      step = STEP_MEDIUM;
    end else begin
      band = MODE_FINE;
      step = STEP_FINE;
    end
    loop_val = {div_reg, stage_reg};
    sum      = {1'b0, loop_val} + {1'b0, step};
    // stage carry or borrow is the only path into the divider
    if (step_up) begin
      if (sum[12:8] > {1'b0, DIV_MAX}) begin
        corr_val = {DIV_MAX, 8'hff};
      end else begin
        corr_val = sum[11:0];
      end
    end else if (loop_val < step) begin
      corr_val = 12'h000;
    end else begin
      corr_val = loop_val - step;
    end
  end

  // ==========================================================
  // bus decode and settling triggers
  always_comb begin
    setup  = psel_i && !penable_i;
    wr     = psel_i && penable_i && pwrite_i && pready_reg;
    mapped = (paddr_i == OFF_CTRL) || (paddr_i == OFF_MULT) ||
             (paddr_i == OFF_TRIM) || (paddr_i == OFF_DIV) ||
             (paddr_i == OFF_STAGE) || (paddr_i == OFF_REF) ||
             (paddr_i == OFF_STATUS);
    restart = 1'b0;
    if (wr && paddr_i == OFF_MULT && pwdata_i[6:0] != mult_reg) begin
      restart = gen_en_reg;
    end
    if (wr && paddr_i == OFF_TRIM && pwdata_i[7:0] != trim_reg) begin
      restart = gen_en_reg;
    end
    if (wr && paddr_i == OFF_CTRL && pwdata_i[0] && !gen_en_reg) begin
      restart = 1'b1;
    end
    corr_fire = meas_valid && gen_en_reg && !restart;
  end

  // ==========================================================
  // register file and loop filter next state
  always_comb begin
    gen_en_next = gen_en_reg;
    mon_en_next = mon_en_reg;
    mult_next   = mult_reg;
    trim_next   = trim_reg;
    div_next    = div_reg;
    stage_next  = stage_reg;
    ref_next    = ref_reg;
    stable_next = stable_reg;
    mode_next   = mode_reg;
    if (wr) begin
      case (paddr_i)
        OFF_CTRL: begin
          gen_en_next = pwdata_i[0];
          // enabling is refused until the clock has settled; disabling never is
          mon_en_next = pwdata_i[1] && stable_reg && !restart;
        end
        OFF_MULT:  mult_next = pwdata_i[6:0];
        OFF_TRIM:  trim_next = pwdata_i[7:0];
        OFF_DIV: begin
          if (!gen_en_reg) begin
            div_next = pwdata_i[3:0];
          end
        end
        OFF_STAGE: begin
          if (!gen_en_reg) begin
            stage_next = pwdata_i[7:0];
          end
        end
        OFF_REF:   ref_next = pwdata_i[9:0];
        default:   mon_en_next = mon_en_reg;
      endcase
    end
    if (corr_fire) begin
      {div_next, stage_next} = corr_val;
      mode_next = band;
      if (band == MODE_FINE) begin
        stable_next = 1'b1;
      end
    end
    // restart from the held or written loop value
    if (restart) begin
      mode_next   = MODE_COARSE;
      stable_next = 1'b0;
    end
    if (!gen_en_next) begin
      mode_next   = MODE_IDLE;
      stable_next = 1'b0;
    end
    div_out_next = (div_next > DIV_MAX) ? DIV_MAX : div_next;
  end

  // ==========================================================
  // read data, captured in setup so the access phase needs no wait
  always_comb begin
    pready_next  = setup;
    pslverr_next = setup && !mapped;
    prdata_next  = 32'h0000_0000;
    if (setup && !pwrite_i) begin
      case (paddr_i)
        // monitor flag lets software check before reprogramming
        OFF_CTRL:   prdata_next = {28'h0, clk_monitor_flag_i,
                                   stable_reg, mon_en_reg,
                                   gen_en_reg};
        OFF_MULT:   prdata_next = {25'h0, mult_reg};
        OFF_TRIM:   prdata_next = {24'h0, trim_reg};
        OFF_DIV:    prdata_next = {28'h0, div_reg};
        OFF_STAGE:  prdata_next = {24'h0, stage_reg};
        OFF_REF:    prdata_next = {22'h0, ref_reg};
        OFF_STATUS: prdata_next = {30'h0, mode_reg};
        default:    prdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      gen_en_reg  <= 1'b1;           // generator runs from reset
      mon_en_reg  <= 1'b0;
      stable_reg  <= 1'b0;
      mult_reg    <= MULT_RST;
      trim_reg    <= TRIM_RST;
      div_reg     <= DIV_RST;
      stage_reg   <= STAGE_RST;
      ref_reg     <= REF_RST;
      mode_reg    <= MODE_COARSE;    // settling begins at reset
      div_out_reg <= DIV_RST;
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      gen_en_reg  <= gen_en_next;
      mon_en_reg  <= mon_en_next;
      stable_reg  <= stable_next;
      mult_reg    <= mult_next;
      trim_reg    <= trim_next;
      div_reg     <= div_next;
      stage_reg   <= stage_next;
      ref_reg     <= ref_next;
      mode_reg    <= mode_next;
      div_out_reg <= div_out_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // ==========================================================
  // outputs
  assign prdata_o         = prdata_reg;
  assign pready_o         = pready_reg;
  assign pslverr_o        = pslverr_reg;
  assign stage_ctrl_o     = stage_reg;
  assign divider_ctrl_o   = div_out_reg;
  assign clk_stable_o     = stable_reg;
  assign monitor_enable_o = mon_en_reg;
  assign mult_factor_o    = mult_reg;
  assign trim_o           = trim_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  div_sat_a: assert property (divider_ctrl_o <= DIV_MAX)
    else $error("divider output above saturation");
  restart_mult_a: assert property (
    (wr && gen_en_reg && paddr_i == OFF_MULT &&
     pwdata_i[6:0] != mult_reg) |=>
    (!clk_stable_o && mode_reg == MODE_COARSE))
    else $error("factor change did not restart settling");
  mon_gate_a: assert property (
    $rose(monitor_enable_o) |-> $past(stable_reg))
    else $error("monitor enabled before stable");
  stable_set_a: assert property (
    (corr_fire && band == MODE_FINE) |=> clk_stable_o)
    else $error("stable flag missed in fine band");
  mult_write_a: assert property (
    (wr && paddr_i == OFF_MULT) |=>
    mult_factor_o == $past(pwdata_i[6:0]))
    else $error("factor write blocked");
  idle_write_a: assert property (
    (wr && !gen_en_reg && paddr_i == OFF_STAGE) |=>
    stage_ctrl_o == $past(pwdata_i[7:0]))
    else $error("stage write lost while disabled");
  coarse_step_a: assert property (
    (corr_fire && band == MODE_COARSE && !wr &&
     loop_val >= 12'h100 && loop_val < 12'h900) |=>
    ((loop_val - $past(loop_val)) == 12'h020 ||
     ($past(loop_val) - loop_val) == 12'h020))
    else $error("coarse step not 32");
  medium_step_a: assert property (
    (corr_fire && band == MODE_MEDIUM && !wr &&
     loop_val >= 12'h100 && loop_val < 12'h900) |=>
    ((loop_val - $past(loop_val)) == 12'h008 ||
     ($past(loop_val) - loop_val) == 12'h008))
    else $error("medium step not 8");
  fine_step_a: assert property (
    (corr_fire && band == MODE_FINE && !wr &&
     loop_val >= 12'h100 && loop_val < 12'h900) |=>
    ((loop_val - $past(loop_val)) == 12'h001 ||
     ($past(loop_val) - loop_val) == 12'h001))
    else $error("fine step not 1");

  stable_rise_c: cover property ($rose(clk_stable_o));
  medium_mode_c: cover property (mode_reg == MODE_MEDIUM);
  div2_used_c:   cover property (ring_div2_o);
  mon_on_c:      cover property ($rose(monitor_enable_o));
endmodule : dco_loop_settling_control

// >>> tb_dco_loop_settling_control.sv
// Purpose: self-checking bench for dco_loop_settling_control
// Assumes: internal clock pin runs at ten system clocks; APB has zero wait states
// Notes:   loop steps are judged against a band model of the count
`timescale 1ns/1ps
module tb_dco_loop_settling_control;
  import dco_pkg::*;
  // ==========
  // nets, model state and counters
  logic        clock_i = 0, rst_i = 1, psel_i = 0, penable_i = 0;
  logic        pwrite_i = 0, internal_clk_i = 0, clock_monitor_flag_i = 0;
  logic [7:0]  paddr_i = 8'h00, stage_ctrl_o, trim_o, sv[4];
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic [3:0]  divider_ctrl_o;
  logic [4:0]  ring_stages_o;
  logic [6:0]  mult_factor_o;
  logic        pready_o, pslverr_o, ring_div2_o, clk_stable_o, se, lng;
  logic        monitor_enable_o;
  int          failures = 0, cmp_count = 0, cycles = 0;
  int          k, n, bad, dlt, gap, base, lv;
  int          refs[3] = '{60, 44, 41};

  dco_loop_settling_control #(.CNT_W(14)) dco_loop_settling_control_i (
    .clock_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .internal_clk_i,
    .clk_monitor_flag_i(clock_monitor_flag_i), .stage_ctrl_o,
    .divider_ctrl_o, .ring_stages_o, .ring_div2_o, .clk_stable_o,
    .monitor_enable_o, .mult_factor_o, .trim_o);

  // pin clock offset by 13 ns so its edges never meet ours
  always #25 clock_i = ~clock_i;
  initial begin
    #13;
    forever #250 internal_clk_i = ~internal_clk_i;
  end

  // hang guard, far above the ~1400 cycles the run needs
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end

  // ==========
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // request held until pready is seen at a rising edge; data and error
  // are taken at that edge, then released; only the hang guard ends it
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clock_i);
    psel_i    <= 1'b1;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clock_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    se = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rchk

  // waits for the next loop correction: signed step and cycles taken
  task automatic step(output int d, output int g);
    logic [11:0] v;
    @(negedge clock_i);
    v = {divider_ctrl_o, stage_ctrl_o};
    g = 0;
    while ({divider_ctrl_o, stage_ctrl_o} === v && g < 400) begin
      @(negedge clock_i);
      g++;
    end
    d = int'({divider_ctrl_o, stage_ctrl_o}) - int'(v);
  endtask : step

  // step the loop should take for a count against four reference periods
  function automatic int band(input int cnt, input int r);
    int e, m;
    e = cnt > 4 * r ? cnt - 4 * r : 4 * r - cnt;
    m = e * 100 > 60 * r ? 32 : (e * 100 > 20 * r ? 8 : 1);
    return cnt < 4 * r ? m : -m;
  endfunction : band

  task automatic conclude();
    if (failures == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  // ==========
  // main sequence
  initial begin
    void'($urandom(32'h017734ca));
    k = $urandom_range(31, 1);
    clock_monitor_flag_i = 1'($urandom_range(1, 0));
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    rchk("ctrl", OFF_CTRL, {28'h0, clock_monitor_flag_i, 3'b001});
    rchk("status", OFF_STATUS, 32'h1);
    rchk("mult", OFF_MULT, 32'h54);
    rchk("stage", OFF_STAGE, 32'h60);
    chk("trim", 32'h80, trim_o);
    rchk("unmapped", 8'h1c, 32'h0);
    chk("slverr", 1, se);
    apb(1'b1, OFF_CTRL, 32'h3);
    rchk("mon off", OFF_CTRL, {28'h0, clock_monitor_flag_i, 3'b001});
    // generator off so stage and divider accept writes
    apb(1'b1, OFF_CTRL, 32'h0);
    apb(1'b1, OFF_DIV, 32'hc);
    @(negedge clock_i);
    chk("divider", 9, divider_ctrl_o);
    sv = '{8'h60, {3'b011, 5'(k)}, {3'b111, 5'(k)}, {3'b000, 5'(k)}};
    foreach (sv[i]) begin
      apb(1'b1, OFF_STAGE, {24'h0, sv[i]});
      repeat (3) @(negedge clock_i);
      base = 17 + 2 * sv[i][7:5];
      n = 0;
      bad = 0;
      repeat (32) begin
        @(negedge clock_i);
        if (sv[i][7:5] == 3'b111) begin
          lng = ring_div2_o === 1'b1 && ring_stages_o === 5'd17;
        end else begin
          lng = ring_stages_o === 5'(base + 2);
        end
        n += lng;
        if (!lng && ring_stages_o !== 5'(base)) bad++;
      end
      chk("long cycles", sv[i][4:0], n);
      chk("base cycles", 0, bad);
    end
    // settle from 0x0f0 so the first coarse step carries into the divider
    apb(1'b1, OFF_DIV, 32'h0);
    apb(1'b1, OFF_STAGE, 32'hf0);
    apb(1'b1, OFF_MULT, 32'h4);
    apb(1'b1, OFF_CTRL, 32'h1);
    @(negedge clock_i);
    chk("start", 12'h0f0, {divider_ctrl_o, stage_ctrl_o});
    lv = 'h0f0;
    foreach (refs[i]) begin
      apb(1'b1, OFF_REF, 32'(refs[i]));
      step(dlt, gap);
      step(dlt, gap);
      lv += 2 * band(160, refs[i]);
      chk("loop step", band(160, refs[i]), dlt);
      chk("period", 1, gap >= 157 && gap <= 163);
      chk("loop value", lv, {divider_ctrl_o, stage_ctrl_o});
    end
    chk("carry", 1, divider_ctrl_o);
    chk("stable", 1, clk_stable_o);
    rchk("fine mode", OFF_STATUS, 32'h2);
    apb(1'b1, OFF_CTRL, 32'h3);
    @(negedge clock_i);
    chk("monitor on", 1, monitor_enable_o);
    // frequency change: flag read, monitor off, then the new factor
    rchk("flag", OFF_CTRL, {28'h0, clock_monitor_flag_i, 3'b111});
    apb(1'b1, OFF_CTRL, 32'h1);
    apb(1'b1, OFF_MULT, 32'h2);
    @(negedge clock_i);
    chk("monitor off", 0, monitor_enable_o);
    chk("restart", 0, clk_stable_o);
    chk("mult out", 2, mult_factor_o);
    rchk("new mult", OFF_MULT, 32'h2);
    rchk("coarse mode", OFF_STATUS, 32'h1);
    // re-enabling before the flag sets again must be refused
    apb(1'b1, OFF_CTRL, 32'h3);
    @(negedge clock_i);
    chk("monitor held", 0, monitor_enable_o);
    step(dlt, gap);
    step(dlt, gap);
    lv += 2 * band(80, 41);
    chk("coarse step", band(80, 41), dlt);
    chk("period", 1, gap >= 77 && gap <= 83);
    chk("loop value", lv, {divider_ctrl_o, stage_ctrl_o});
    apb(1'b1, OFF_TRIM, 32'h7f);
    @(negedge clock_i);
    chk("trim", 32'h7f, trim_o);
    rchk("trim restart", OFF_STATUS, 32'h1);
    conclude();
  end
endmodule : tb_dco_loop_settling_control
